// [src/dam_pkg.sv]
package dam_pkg;
   // ==========================================================
   // widths and pipeline shape
   localparam int RES_W = 12;
   localparam int STAGES = 12;
   localparam int STAGES_PER_LVL = 2;
   localparam int LEVELS = STAGES / STAGES_PER_LVL;
   localparam int LATENCY = 7;
   localparam int CHANNELS = 2;
   localparam int CH_I = 0;
   localparam int CH_Q = 1;
   localparam int DIG_W = 2 * STAGES;
   localparam int SUM_W = RES_W + 2;
   localparam int STEP_W = RES_W + 2;
   localparam int CNT_W = 4;
   // ==========================================================
   // stage decision levels, full scale is 4096 codes
   localparam logic [RES_W-1:0] LOW_THRESH = 12'h400;
   localparam logic [RES_W-1:0] HIGH_THRESH = 12'hC00;
   localparam logic [RES_W:0] HALF_SCALE = 13'h0800;
   localparam logic [RES_W:0] FULL_SCALE = 13'h1000;
   localparam logic [RES_W-1:0] CODE_MAX = 12'hFFF;
   localparam logic [1:0] DIGIT_LOW = 2'h0;
   localparam logic [1:0] DIGIT_MID = 2'h1;
   localparam logic [1:0] DIGIT_HIGH = 2'h2;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int LINK_DELAY = 2;
   localparam logic [CNT_W-1:0] WARMUP_CYCLES = CNT_W'(LATENCY + LINK_DELAY);
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   // ==========================================================
   // capture modes
   typedef enum logic [2:0] {
      MODE_I = 3'h1,
      MODE_Q = 3'h2,
      MODE_IQ = 3'h4
   } dam_mode_e;
endpackage

// [src/dam_if.sv]
`timescale 1ns/1ps
interface dam_if;
   logic [dam_pkg::RES_W-1:0] shared_result_bus;
   logic [dam_pkg::RES_W-1:0] busLevel;
   logic busOe;
   logic selectLine;
   logic output_disable_n;
   // wire level seen by the receiver; a released bus reads
   // inverted, so a capture while floating cannot pass unseen
   assign busLevel = busOe ? shared_result_bus : ~shared_result_bus;
   modport adc (
      input selectLine,
      input output_disable_n,
      output shared_result_bus,
      output busOe
   );
   modport capture (
      input busLevel,
      input busOe,
      output selectLine,
      output output_disable_n
   );
endinterface

// [src/dam_adc_end.sv]
`timescale 1ns/1ps
module dam_adc_end (
   input wire logic clk,
   input wire logic rst,
   input wire logic [dam_pkg::RES_W-1:0] sampleI,
   input wire logic [dam_pkg::RES_W-1:0] sampleQ,
   dam_if.adc link
);
   import dam_pkg::*;

   // ==========================================================
   // stage arithmetic
   // one redundant stage: three-way decision, residue doubled;
   // the overlap lets late correction absorb comparator offsets
   function automatic logic [STEP_W-1:0] stage_step(
      input logic [RES_W-1:0] res
   );
      logic [RES_W:0] twice;
      logic [RES_W:0] diff;
      twice = {res, 1'b0};
      diff = '0;
      if (res < LOW_THRESH) begin
         stage_step = {DIGIT_LOW, twice[RES_W-1:0]};
      end else if (res < HIGH_THRESH) begin
         diff = twice - HALF_SCALE;
         stage_step = {DIGIT_MID, diff[RES_W-1:0]};
      end else begin
         diff = twice - FULL_SCALE;
         stage_step = {DIGIT_HIGH, diff[RES_W-1:0]};
      end
   endfunction

   // overlapping digits are summed and clipped to the code range;
   // the last digit weighs half an LSB, so the sum is halved and
   // its low bit rounds the code back up
   function automatic logic [RES_W-1:0] correct_code(
      input logic [DIG_W-1:0] digits
   );
      logic [SUM_W-1:0] sum;
      logic [SUM_W-1:0] halved;
      sum = '0;
      halved = '0;
      for (int k = 0; k < STAGES; k++) begin
         sum = sum + (SUM_W'(digits[2*k +: 2]) << (STAGES - 1 - k));
      end
      halved = (sum >> 1) + SUM_W'(sum[0]);
      if (halved > SUM_W'(CODE_MAX)) begin
         correct_code = CODE_MAX;
      end else begin
         correct_code = halved[RES_W-1:0];
      end
   endfunction

   // ==========================================================
   // pipeline storage
   // level 0 is the held sample; level n has passed 2n stages
   logic [RES_W-1:0] resReg [CHANNELS][LEVELS+1];
   logic [DIG_W-1:0] digReg [CHANNELS][LEVELS+1];
   logic [RES_W-1:0] sampleIn [CHANNELS];
   logic [RES_W-1:0] busReg;
   logic [RES_W-1:0] busNext;
   logic oeReg;

   assign sampleIn[CH_I] = sampleI;
   assign sampleIn[CH_Q] = sampleQ;

   // ==========================================================
   // per-channel conversion
   // data path carries no reset: a stale pipeline flushes in
   // seven clocks, which the receiver's warm-up already covers
   genvar ch;
   genvar lvl;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         always_ff @(posedge clk) begin
            resReg[ch][0] <= sampleIn[ch];
            digReg[ch][0] <= '0;
         end

         for (lvl = 1; lvl <= LEVELS; lvl++) begin : g_lvl
            logic [STEP_W-1:0] firstStep;
            logic [STEP_W-1:0] secondStep;
            logic [DIG_W-1:0] digNext;

            always_comb begin
               firstStep = stage_step(resReg[ch][lvl-1]);
               secondStep = stage_step(firstStep[RES_W-1:0]);
            end

            // earlier digits ride along, so all meet in step
            always_comb begin
               digNext = digReg[ch][lvl-1];
               digNext[2*STAGES_PER_LVL*(lvl-1) +: 2] = firstStep[STEP_W-1:RES_W];
               digNext[2*STAGES_PER_LVL*(lvl-1)+2 +: 2] = secondStep[STEP_W-1:RES_W];
            end

            always_ff @(posedge clk) begin
               resReg[ch][lvl] <= secondStep[RES_W-1:0];
               digReg[ch][lvl] <= digNext;
            end
         end
      end
   endgenerate

   // ==========================================================
   // output multiplexer
   // correction and channel choice share the last clock, so the
   // word stands on the bus exactly LATENCY edges after sampling
   always_comb begin
      if (link.selectLine) begin
         busNext = correct_code(digReg[CH_I][LEVELS]);
      end else begin
         busNext = correct_code(digReg[CH_Q][LEVELS]);
      end
   end

   // select is sampled at the edge: toggling it each clock
   // alternates I and Q words, the synchronous form of tying it
   // to the clock
   always_ff @(posedge clk) begin
      if (rst) begin
         busReg <= '0;
      end else begin
         busReg <= busNext;
      end
   end

   // ==========================================================
   // output enable
   // disable only gates the buffers; the pipeline never stops
   always_ff @(posedge clk) begin
      if (rst) begin
         oeReg <= 1'b0;
      end else begin
         oeReg <= ~link.output_disable_n;
      end
   end

   assign link.shared_result_bus = busReg;
   assign link.busOe = oeReg;
endmodule

// [src/dam_capture_end.sv]
`timescale 1ns/1ps
module dam_capture_end (
   input wire logic clk,
   input wire logic rst,
   input wire dam_pkg::dam_mode_e modeReq,
   input wire logic chipSelect,
   input wire logic wordReady,
   output logic [dam_pkg::RES_W-1:0] wordData,
   output logic wordChanI,
   output logic wordValid,
   dam_if.capture link
);
   import dam_pkg::*;

   // ==========================================================
   // link control
   dam_mode_e modeReg;
   logic selectReg;
   logic selDlyReg;
   logic odnReg;
   logic [CNT_W-1:0] warmCnt;
   logic warmDone;
   logic [RES_W-1:0] capData;
   logic capChan;
   logic capValid;
   logic fillReady;
   logic [RES_W-1:0] skidData;
   logic skidChan;
   logic skidValid;

   assign warmDone = (warmCnt == WARMUP_CYCLES);
   assign fillReady = ~skidValid;

   always_ff @(posedge clk) begin
      if (rst) begin
         modeReg <= MODE_I;
      end else begin
         modeReg <= modeReq;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         selectReg <= 1'b1;
      end else begin
         case (modeReg)
            MODE_I: selectReg <= 1'b1;
            MODE_Q: selectReg <= 1'b0;
            MODE_IQ: selectReg <= ~selectReg;
            default: selectReg <= 1'b1;
         endcase
      end
   end

   // the bus word read now was chosen by select two edges back
   always_ff @(posedge clk) begin
      if (rst) begin
         selDlyReg <= 1'b1;
      end else begin
         selDlyReg <= selectReg;
      end
   end

   // deselect while stalled; words in flight then are skipped
   always_ff @(posedge clk) begin
      if (rst) begin
         odnReg <= 1'b1;
      end else begin
         odnReg <= ~chipSelect | (capValid & ~fillReady);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         warmCnt <= '0;
      end else if (!warmDone) begin
         warmCnt <= warmCnt + CNT_ONE;
      end
   end

   // ==========================================================
   // capture register
   always_ff @(posedge clk) begin
      if (rst) begin
         capValid <= 1'b0;
         capData <= '0;
         capChan <= 1'b0;
      end else if (!capValid || fillReady) begin
         capValid <= link.busOe & warmDone;
         capData <= link.busLevel;
         capChan <= selDlyReg;
      end
   end

   // ==========================================================
   // two-entry buffer: output stage plus skid slot
   always_ff @(posedge clk) begin
      if (rst) begin
         wordValid <= 1'b0;
         wordData <= '0;
         wordChanI <= 1'b0;
         skidValid <= 1'b0;
         skidData <= '0;
         skidChan <= 1'b0;
      end else if (!wordValid || wordReady) begin
         if (skidValid) begin
            wordValid <= 1'b1;
            wordData <= skidData;
            wordChanI <= skidChan;
            skidValid <= 1'b0;
         end else begin
            wordValid <= capValid;
            wordData <= capData;
            wordChanI <= capChan;
         end
      end else if (capValid && fillReady) begin
         skidValid <= 1'b1;
         skidData <= capData;
         skidChan <= capChan;
      end
   end

   assign link.selectLine = selectReg;
   assign link.output_disable_n = odnReg;
endmodule

// [dv/dam_chk.sv]
`timescale 1ns/1ps
// ========
// wire checks beside the link
module dam_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [dam_pkg::RES_W-1:0] sampleI,
   input wire logic [dam_pkg::RES_W-1:0] sampleQ,
   input wire logic [dam_pkg::RES_W-1:0] shared_result_bus,
   input wire logic [dam_pkg::RES_W-1:0] busLevel,
   input wire logic busOe,
   input wire logic selectLine,
   input wire logic output_disable_n
);
   logic [3:0] warmCnt;
   logic warm;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // data pipe has no reset, so wait until it has flushed
   assign warm = warmCnt >= 4'h8;
   always_ff @(posedge clk) begin
      if (rst) begin
         warmCnt <= 4'h0;
      end else if (!warm) begin
         warmCnt <= warmCnt + 4'h1;
      end
   end
   // bus content is unknown until the pipe has flushed
   sequence s_reenable;
      warm && $fell(output_disable_n);
   endsequence
   sequence s_driving;
      busOe ##0 busLevel == shared_result_bus;
   endsequence
   // ========
   // assertions
   a_i_latency: assert property (
      warm && $past(selectLine) |-> shared_result_bus == $past(sampleI, 8))
      else $error("I word not seven clocks after its sample");
   a_q_latency: assert property (
      warm && !$past(selectLine) |-> shared_result_bus == $past(sampleQ, 8))
      else $error("Q word not seven clocks after its sample");
   a_oe_follow: assert property (
      !$past(rst) |-> busOe == !$past(output_disable_n))
      else $error("drive enable does not follow disable input");
   a_float_after: assert property (
      $rose(output_disable_n) |=> !busOe)
      else $error("bus still driven after disable");
   a_float_hold: assert property (
      output_disable_n [*2] |-> !busOe)
      else $error("bus driven while disabled");
   a_turn_on: assert property (
      s_reenable |=> s_driving)
      else $error("bus not back one clock after enable");
   a_oe_delay: assert property (
      $fell(output_disable_n) |-> ##[1:2] busOe)
      else $error("turn-on delay too long");
   a_level_drive: assert property (
      warm && busOe |-> busLevel == shared_result_bus)
      else $error("wire level differs from driven word");
endmodule

// [dv/dual_adc_output_mux_bench.sv]
`timescale 1ns/1ps
module dual_adc_output_mux_bench;
   import dam_pkg::*;
   logic clk, rst, chipSelect, wordReady, wordChanI, wordValid, prevChan, havePrev, resync;
   logic [11:0] sampleI, sampleQ, wordData, prevWord;
   dam_mode_e modeReq;
   int bad_count, comparisons, cyc, words;
   dam_if dam_if_i ();
   dam_adc_end dam_adc_end_i (.clk(clk), .rst(rst), .sampleI(sampleI), .sampleQ(sampleQ),
      .link(dam_if_i.adc));
   dam_capture_end dam_capture_end_i (.clk(clk), .rst(rst), .modeReq(modeReq),
      .chipSelect(chipSelect), .wordReady(wordReady), .wordData(wordData),
      .wordChanI(wordChanI), .wordValid(wordValid), .link(dam_if_i.capture));
   dam_chk dam_chk_i (.clk(clk), .rst(rst), .sampleI(sampleI), .sampleQ(sampleQ),
      .shared_result_bus(dam_if_i.shared_result_bus), .busLevel(dam_if_i.busLevel),
      .busOe(dam_if_i.busOe), .selectLine(dam_if_i.selectLine),
      .output_disable_n(dam_if_i.output_disable_n));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(string what, logic [11:0] exp, logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ========
   // sample stream: bit 11 marks the channel, low bits count clocks
   always @(negedge clk) begin
      cyc <= cyc + 1;
      sampleI <= 12'(cyc) & 12'h7FF;
      sampleQ <= 12'(cyc) | 12'h800;
      if (cyc > 1500) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ========
   // consumer side: words must be consecutive samples with the right tag
   always @(posedge clk) begin
      if (wordValid === 1'b1 && wordReady) begin
         words++;
         check("channel tag", {11'h0, ~wordData[11]}, {11'h0, wordChanI});
         if (havePrev && !resync) begin
            check("word order", {1'b0, prevWord[10:0] + 11'h1}, {1'b0, wordData[10:0]});
            if (modeReq != MODE_IQ) check("mode", {11'h0, modeReq == MODE_I}, {11'h0, wordChanI});
            else check("interleave", {11'h0, ~prevChan}, {11'h0, wordChanI});
         end
         prevWord = wordData;
         prevChan = wordChanI;
         havePrev = 1'b1;
      end
   end
   // mode changes and stalls leave a gap, so settle before checking order
   task run(dam_mode_e m, string name);
      resync = 1'b1;
      modeReq = m;
      repeat (20) @(negedge clk);
      resync = 1'b0;
      words = 0;
      repeat (30) @(negedge clk);
      check("words seen", 12'h1, {11'h0, words > 20});
      $display("test %s done", name);
   endtask
   initial begin
      rst = 1'b1;
      chipSelect = 1'b1;
      wordReady = 1'b1;
      modeReq = MODE_I;
      cyc = 0;
      sampleI = 12'h000;
      sampleQ = 12'h800;
      havePrev = 1'b0;
      resync = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (8) begin
         @(negedge clk);
         check("warm-up valid", 12'h0, {11'h0, wordValid});
      end
      $display("test warm-up done");
      run(MODE_I, "select I");
      run(MODE_Q, "select Q");
      run(MODE_IQ, "interleave");
      wordReady = 1'b0;
      repeat (10) @(negedge clk);
      check("stall hold", 12'h1, {11'h0, wordValid});
      check("stall float", 12'h0, {11'h0, dam_if_i.busOe});
      wordReady = 1'b1;
      run(MODE_IQ, "stall");
      chipSelect = 1'b0;
      repeat (5) @(negedge clk);
      check("deselect float", 12'h0, {11'h0, dam_if_i.busOe});
      chipSelect = 1'b1;
      repeat (3) @(negedge clk);
      check("reselect drive", 12'h1, {11'h0, dam_if_i.busOe});
      run(MODE_IQ, "chip select");
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      run(MODE_Q, "second reset");
      report_and_stop();
   end
endmodule
